//--- dws_host.v
// Host-side controller for a 4K x 4 asynchronous static memory.
// Assumes the memory pins are wired straight to the ports below and
// that pin inputs are synchronous to CORE_CLK.
`timescale 1ns/100ps
`include "dwsram_defines.vh"
module dws_host
(
   // Clock and reset
   input  wire                   CORE_CLK,
   input  wire                   NRST,
   // User request
   input  wire                   REQ_VALID,
   input  wire                   REQ_WRITE,
   input  wire [`DWS_ADDR_W-1:0] REQ_ADDR,
   input  wire [`DWS_DATA_W-1:0] REQ_WDATA,
   output reg                    REQ_READY,
   // User answer
   output reg                    RSP_VALID,
   output reg  [`DWS_DATA_W-1:0] RSP_RDATA,
   // Memory pins
   output reg  [`DWS_ADDR_W-1:0] WORD_INDEX,
   output reg  [`DWS_DATA_W-1:0] WRITE_IN_BITS,
   output reg                    SELECT_N,
   output reg                    WRITE_STROBE_A_N,
   output reg                    WRITE_STROBE_B_N,
   input  wire [`DWS_DATA_W-1:0] READ_OUT_BITS
);

   ////////////////////////////////////////////////////////////////////
   // States
   localparam [2:0] ST_IDLE  = 3'h0;  // Deselected, ready
   localparam [2:0] ST_RWAIT = 3'h1;  // Read access time
   localparam [2:0] ST_WSET  = 3'h2;  // Address setup before strobes
   localparam [2:0] ST_WPULS = 3'h3;  // Both strobes low
   localparam [2:0] ST_WHOLD = 3'h4;  // Address/data hold
   localparam [2:0] ST_WREC  = 3'h5;  // Write recovery

   // A read holds the pins for the access time and samples once.
   // A write walks setup, strobe pulse, hold and recovery, so the
   // memory never sees an address move while a store is open.
   // Only one transfer is in flight; a user waits for the answer
   // pulse before the next request is taken.

   ////////////////////////////////////////////////////////////////////
   // Phase lengths in core clock cycles
   // The header counts are plain integers; each is cut to the timer
   // width on purpose, since all of them fit in three bits. A slower
   // memory grade would need a wider timer, not a silent wrap.
   localparam integer WSA_INT = `DWS_WSA_CYC;   // Address setup
   localparam integer W_INT   = `DWS_W_CYC;     // Strobe low time
   localparam integer WHA_INT = `DWS_WHA_CYC;   // Address and data hold
   localparam integer WR_INT  = `DWS_WR_CYC;    // Write recovery
   localparam integer AA_INT  = `DWS_AA_CYC;    // Read access plus margin

   localparam [2:0]   LD_WSA  = WSA_INT[2:0];   // Timer load, setup
   localparam [2:0]   LD_W    = W_INT[2:0];     // Timer load, pulse
   localparam [2:0]   LD_WHA  = WHA_INT[2:0];   // Timer load, hold
   localparam [2:0]   LD_WR   = WR_INT[2:0];    // Timer load, recovery
   localparam [2:0]   LD_AA   = AA_INT[2:0];    // Timer load, access

   reg  [2:0] state_q;   // Current state
   reg        ld;        // Load phase timer
   reg  [2:0] ld_cnt;    // Phase length
   wire       ph_done;   // Phase elapsed

   ////////////////////////////////////////////////////////////////////
   // Phase timer
   // One shared down counter; each transition into a timed state loads the next phase length, returns to idle load nothing
   dws_wait u_wait
   (
      .clk   (CORE_CLK),
      .nrst  (NRST),
      .load  (ld),
      .count (ld_cnt),
      .done  (ph_done)
   );

   // Timer load decisions, one per transition out of idle, setup, pulse and hold
   always @*
   begin
      ld     = 1'b0;
      ld_cnt = 3'h0;
      case (state_q)
         ST_IDLE:
         begin
            if (REQ_VALID & REQ_READY)
            begin
               ld     = 1'b1;
               // Writes open with address setup, reads with access time
               ld_cnt = REQ_WRITE ? LD_WSA : LD_AA;
            end
         end
         ST_WSET:
         begin
            if (ph_done)
            begin
               ld     = 1'b1;
               // Setup elapsed: time the strobe pulse next
               ld_cnt = LD_W;
            end
         end
         ST_WPULS:
         begin
            if (ph_done)
            begin
               ld     = 1'b1;
               // Pulse elapsed: time the address and data hold
               ld_cnt = LD_WHA;
            end
         end
         ST_WHOLD:
         begin
            if (ph_done)
            begin
               ld     = 1'b1;
               // Hold elapsed: time the write recovery
               ld_cnt = LD_WR;
            end
         end
         default:
         begin
            // Read wait and recovery run the timer down from their load
            ld     = 1'b0;
            ld_cnt = 3'h0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer; every pin comes from a flip-flop
   always @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         // Pins idle: deselected, strobes high, bus lines low
         state_q          <= ST_IDLE;
         REQ_READY        <= 1'b0;
         RSP_VALID        <= 1'b0;
         RSP_RDATA        <= 4'h0;
         WORD_INDEX       <= 12'h000;
         WRITE_IN_BITS    <= 4'h0;
         SELECT_N         <= 1'b1;   // Deselected: memory ignores strobes [R02]
         WRITE_STROBE_A_N <= 1'b1;
         WRITE_STROBE_B_N <= 1'b1;
      end
      else
      begin
         // Answer pulse lasts one cycle unless set below
         RSP_VALID <= 1'b0;
         case (state_q)
            ST_IDLE:
            begin
               // Ready one cycle after every return to idle
               REQ_READY <= 1'b1;
               if (REQ_VALID & REQ_READY)
               begin
                  // Address and data launch with select; strobes wait
                  REQ_READY     <= 1'b0;
                  WORD_INDEX    <= REQ_ADDR;              // [R01]
                  WRITE_IN_BITS <= REQ_WDATA;
                  SELECT_N      <= 1'b0;
                  // Strobes stay high here, so a read is seen [R04]
                  state_q       <= REQ_WRITE ? ST_WSET : ST_RWAIT;
               end
            end
            ST_RWAIT:
            begin
               if (ph_done)
               begin
                  // Sample only after access time; data is stable then [R04]
                  RSP_RDATA <= READ_OUT_BITS;
                  RSP_VALID <= 1'b1;
                  SELECT_N  <= 1'b1;                      // [R02]
                  state_q   <= ST_IDLE;
               end
            end
            ST_WSET:
            begin
               if (ph_done)
               begin
                  // Both strobes fall together to store [R05] [R03]
                  WRITE_STROBE_A_N <= 1'b0;
                  WRITE_STROBE_B_N <= 1'b0;
                  state_q          <= ST_WPULS;
               end
            end
            ST_WPULS:
            begin
               if (ph_done)
               begin
                  // Rise together; address and data still held [R05]
                  WRITE_STROBE_A_N <= 1'b1;
                  WRITE_STROBE_B_N <= 1'b1;
                  state_q          <= ST_WHOLD;
               end
            end
            ST_WHOLD:
            begin
               if (ph_done)
               begin
                  // Select rises only after the hold time
                  SELECT_N <= 1'b1;                       // [R02]
                  state_q  <= ST_WREC;
               end
            end
            ST_WREC:
            begin
               // Recovery keeps the outputs settled before any read
               // The user sees the write done only after recovery
               if (ph_done)
               begin
                  RSP_VALID <= 1'b1;
                  state_q   <= ST_IDLE;
               end
            end
            default:
               // Unused codes fall back to idle
               state_q <= ST_IDLE;
         endcase
      end
   end

endmodule

//--- dwsram_defines.vh
// Constants for the host-side controller of a 4K x 4 static memory
// with separate data in/out, active-low select and two write strobes.
// Assumes a 200 MHz core clock; the memory itself has no clock.
//
// Overview of operation
// [R01] Memory holds 4K words of 4 bits
// [R02] Select high: writes ignored, outputs low
// [R03] Write needs select and both strobes low
// [R04] Read: select low, one strobe high
// [R05] Host drives both strobes low to store
`ifndef DWSRAM_DEFINES_VH
`define DWSRAM_DEFINES_VH

// Geometry
`define DWS_ADDR_W        12
`define DWS_DATA_W        4

// Timing figures in ns and the core clock period in ns
`define DWS_CLK_PERIOD_NS 5
`define DWS_T_AA_NS       15
`define DWS_T_W_NS        15
`define DWS_T_WSA_NS      3
`define DWS_T_WHA_NS      2
`define DWS_T_WR_NS       17

// Cycle counts: least times round up, at least one cycle
`define DWS_CYC_UP(t)     (((t) + `DWS_CLK_PERIOD_NS - 1) / `DWS_CLK_PERIOD_NS)
`define DWS_AA_CYC        (`DWS_CYC_UP(`DWS_T_AA_NS) + 1)
`define DWS_W_CYC         `DWS_CYC_UP(`DWS_T_W_NS)
`define DWS_WSA_CYC       `DWS_CYC_UP(`DWS_T_WSA_NS)
`define DWS_WHA_CYC       `DWS_CYC_UP(`DWS_T_WHA_NS)
`define DWS_WR_CYC        `DWS_CYC_UP(`DWS_T_WR_NS)

`endif

//--- dws_wait.v
// Down counter used to time each phase of a memory access.
// Assumes the caller loads it and watches the done flag.
`timescale 1ns/100ps
module dws_wait
(
   // Clock and reset
   input  wire       clk,
   input  wire       nrst,
   // Control
   input  wire       load,
   input  wire [2:0] count,
   // Status
   output wire       done
);

   reg [2:0] cnt_q;   // Cycles left in the phase

   // Load wins over counting so a new phase starts cleanly
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         cnt_q <= 3'h0;
      else if (load)
         cnt_q <= count;
      else if (cnt_q != 3'h0)
         cnt_q <= cnt_q - 3'h1;
   end

   // Done is the count alone and never looks at load: the caller
   // decides load from done, so the two would form a zero-delay loop
   assign done = (cnt_q == 3'h0);

endmodule

//--- dws_sram_model.sv
// Behavioural 4K x 4 memory on the host's pins.
// Assumes the host drives every pin; no clock here.
`timescale 1ns/100ps
module dws_sram_model
(
   // Memory pins
   input  wire [11:0] word_index,
   input  wire [3:0]  write_in_bits,
   input  wire        select_n,
   input  wire        write_strobe_a_n,
   input  wire        write_strobe_b_n,
   output wire [3:0]  read_out_bits
);
   // Storage, 4K words of 4 bits
   reg [3:0] mem_q [0:4095];
   // Store only with select and both strobes low
   always @*
   begin
      if (!select_n && !write_strobe_a_n && !write_strobe_b_n)
         mem_q[word_index] = write_in_bits;
   end
   // Low when idle or writing; data inputs ignored on reads
   assign read_out_bits = (!select_n && (write_strobe_a_n || write_strobe_b_n))
                          ? mem_q[word_index] : 4'h0;
endmodule

//--- dws_host_monitor.sv
// Pin checker for dws_host.
// Assumes the bind below.
`timescale 1ns/100ps
module dws_host_monitor
(
   // Clock, reset, watched ports
   input wire        CORE_CLK,
   input wire        NRST,
   input wire        REQ_READY,
   input wire        SELECT_N,
   input wire        WRITE_STROBE_A_N,
   input wire        WRITE_STROBE_B_N,
   input wire [11:0] WORD_INDEX,
   input wire [3:0]  WRITE_IN_BITS
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   chk_strobe_pair: assert property (WRITE_STROBE_A_N == WRITE_STROBE_B_N)
      else $error("strobes differ");
   chk_write_select: assert property (!WRITE_STROBE_A_N |-> !SELECT_N)
      else $error("write strobe without select");
   chk_write_hold: assert property (!WRITE_STROBE_A_N ##1 !WRITE_STROBE_A_N |->
      $stable(WORD_INDEX) && $stable(WRITE_IN_BITS))
      else $error("pins moved in write");
   chk_strobe_width: assert property ($fell(WRITE_STROBE_A_N) |->
      !WRITE_STROBE_A_N[*3] ##[0:2] WRITE_STROBE_A_N)
      else $error("strobe width wrong");
   chk_idle_deselect: assert property (REQ_READY |-> SELECT_N)
      else $error("selected while idle");
   chk_read_addr: assert property (!SELECT_N && $past(!SELECT_N) |->
      $stable(WORD_INDEX))
      else $error("address moved in access");
endmodule
bind dws_host dws_host_monitor u_dws_host_monitor (.CORE_CLK(CORE_CLK), .NRST(NRST),
   .REQ_READY(REQ_READY), .SELECT_N(SELECT_N), .WRITE_STROBE_A_N(WRITE_STROBE_A_N),
   .WRITE_STROBE_B_N(WRITE_STROBE_B_N), .WORD_INDEX(WORD_INDEX),
   .WRITE_IN_BITS(WRITE_IN_BITS));

//--- dws_host_tb.sv
// Self-checking bench: dws_host with a memory model.
// Assumes the checker binds itself.
`timescale 1ns/100ps
module dws_host_tb;
   reg         CORE_CLK;
   reg         NRST;
   reg         REQ_VALID;
   reg         REQ_WRITE;
   reg  [11:0] REQ_ADDR;
   reg  [3:0]  REQ_WDATA;
   wire        REQ_READY;
   wire        RSP_VALID;
   wire [3:0]  RSP_RDATA;
   wire [11:0] WORD_INDEX;
   wire [3:0]  WRITE_IN_BITS;
   wire        SELECT_N;
   wire        WRITE_STROBE_A_N;
   wire        WRITE_STROBE_B_N;
   wire [3:0]  READ_OUT_BITS;
   reg  [4:0]  exp_q[$];        // {is_read, data}
   reg  [4:0]  ent;
   reg  [3:0]  ref_mem [0:4095];
   reg  [11:0] adr [0:5];
   integer     error_cnt;
   integer     checks;
   integer     i;
   dws_host u_dws_host (.CORE_CLK(CORE_CLK), .NRST(NRST), .REQ_VALID(REQ_VALID),
      .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
      .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
      .WORD_INDEX(WORD_INDEX), .WRITE_IN_BITS(WRITE_IN_BITS), .SELECT_N(SELECT_N),
      .WRITE_STROBE_A_N(WRITE_STROBE_A_N), .WRITE_STROBE_B_N(WRITE_STROBE_B_N),
      .READ_OUT_BITS(READ_OUT_BITS));
   dws_sram_model u_dws_sram_model (.word_index(WORD_INDEX),
      .write_in_bits(WRITE_IN_BITS), .select_n(SELECT_N),
      .write_strobe_a_n(WRITE_STROBE_A_N), .write_strobe_b_n(WRITE_STROBE_B_N),
      .read_out_bits(READ_OUT_BITS));
   always #2.5 CORE_CLK = ~CORE_CLK;
   task check(input [3:0] seen, input [3:0] exp);
   begin
      checks = checks + 1;
      if (seen !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   task stop_test;
   begin
      if (error_cnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   // One request, entered at a falling edge; bounded wait for ready
   task op(input w, input [11:0] a, input [3:0] d);
   begin
      i = 0;
      while (REQ_READY !== 1'b1 && i < 40)
      begin
         @(negedge CORE_CLK);
         i = i + 1;
      end
      if (REQ_READY !== 1'b1)
         check(4'hE, 4'h0);
      if (REQ_READY !== 1'b1)
         stop_test;
      REQ_VALID = 1'b1;
      REQ_WRITE = w;
      REQ_ADDR = a;
      REQ_WDATA = d;
      exp_q.push_back({!w, ref_mem[a]});
      if (w)
         ref_mem[a] = d;
      @(negedge CORE_CLK);
      REQ_VALID = 1'b0;
   end
   endtask
   // Oldest note against each answer; read data only
   always @(negedge CORE_CLK)
   begin
      if (RSP_VALID === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(4'hF, 4'h0);
         else
         begin
            ent = exp_q.pop_front();
            if (ent[4])
               check(RSP_RDATA, ent[3:0]);
         end
      end
   end
   initial
   begin
      CORE_CLK = 1'b0;
      NRST = 1'b0;
      REQ_VALID = 1'b0;
      REQ_WRITE = 1'b0;
      REQ_ADDR = 12'h000;
      REQ_WDATA = 4'h0;
      error_cnt = 0;
      checks = 0;
      i = $urandom(35);
      repeat (10) @(negedge CORE_CLK);
      NRST = 1'b1;
      @(negedge CORE_CLK);
      check({3'h0, SELECT_N}, 4'h1);
      adr[0] = 12'h000;
      adr[1] = 12'hFFF;
      for (int k = 2; k < 6; k = k + 1)
         adr[k] = 12'($urandom);
      // Back to back writes, one overwrite, reads with junk write data
      for (int k = 0; k < 6; k = k + 1)
         op(1'b1, adr[k], 4'($urandom));
      op(1'b1, adr[1], ~ref_mem[adr[1]]);
      for (int k = 5; k >= 0; k = k - 1)
         op(1'b0, adr[k], 4'($urandom));
      repeat (30) @(negedge CORE_CLK);
      check(4'(exp_q.size()), 4'h0);
      stop_test;
   end
endmodule
